// File: verilog/pimc_phy.sv
// Device end: per-port mode registers, commit on software reset, mode decode
//
// The Wishbone register port and the register offsets are this design's own decisions.
`include "pimc_consts.svh"
module pimc_phy #(
  parameter int PORTS = 2
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  pimc_if.phy mgmt,
  input wire logic [PORTS-1:0] sig_det_i,
  input wire logic [PORTS-1:0] fiber_ok_i,
  input wire logic [PORTS-1:0] copper_ok_i,
  input wire logic [PORTS-1:0] sfp_link_i,
  output logic [1:0] mac_mode_o [PORTS],
  output logic [1:0] media_mode_o [PORTS],
  output logic [PORTS-1:0] port_active_o,
  output logic [PORTS-1:0] mac_an_run_o,
  output logic [PORTS-1:0] fiber_an_run_o,
  output logic [PORTS-1:0] speed_1000_only_o,
  output logic [PORTS-1:0] tx_enable_o,
  output logic [PORTS-1:0] link_up_o,
  output logic [PORTS-1:0] diag_enable_o,
  output logic [PORTS-1:0] led_link_o,
  output logic [PORTS-1:0] led_fault_en_o,
  output logic [1:0] qsgmii_lanes_o
);
  // ====================
  // Pin synchronisers
  logic [PORTS-1:0] det_s1, det_s2, fib_s1, fib_s2, cu_s1, cu_s2, sl_s1, sl_s2;
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      det_s1 <= '0; det_s2 <= '0; fib_s1 <= '0; fib_s2 <= '0;
      cu_s1 <= '0; cu_s2 <= '0; sl_s1 <= '0; sl_s2 <= '0;
    end
    else
    begin
      det_s1 <= sig_det_i; det_s2 <= det_s1; fib_s1 <= fiber_ok_i; fib_s2 <= fib_s1;
      cu_s1 <= copper_ok_i; cu_s2 <= cu_s1; sl_s1 <= sfp_link_i; sl_s2 <= sl_s1;
    end

  // ====================
  // Registers
  logic [1:0] gmode, gmode_live;
  logic bcast;
  logic [15:0] mode_pend [PORTS];
  logic [15:0] mode_live [PORTS];
  logic [15:0] ctrl [PORTS];
  logic [15:0] adv [PORTS];
  logic [PORTS-1:0] mac_an;
  logic [1:0] media_sel [PORTS];
  logic wr;
  assign wr = mgmt.req & mgmt.we & ~mgmt.ack;

  function automatic logic hit(input logic [0:0] p, input int i, input logic bc);
    hit = bc || (p == i[0:0]);
  endfunction : hit

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      gmode <= `PIMC_MACMODE_SGMII;
      bcast <= 1'b0;
    end
    else if (wr && mgmt.addr == `PIMC_A_GLOBAL)
      gmode <= mgmt.wdata[`PIMC_B_MACMODE_HI:`PIMC_B_MACMODE_LO];
    else if (wr && mgmt.addr == `PIMC_A_BCAST)
      bcast <= mgmt.wdata[`PIMC_B_BCAST];

  // Global mode also waits for a software reset on any port
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
    if (!rst_n_i)
      gmode_live <= `PIMC_MACMODE_SGMII;
    else if (wr && mgmt.addr == `PIMC_A_CTRL && mgmt.wdata[`PIMC_B_SWRST])
      gmode_live <= gmode;

  genvar g;
  generate
    for (g = 0; g < PORTS; g++)
    begin : gp
      logic sel, swrst;
      logic [15:0] ml;
      pimc_pkg::pimc_mac_e mm;
      pimc_pkg::pimc_media_e md;
      logic sense_on, uni, ok;
      assign sel = hit(mgmt.port, g, bcast);
      assign swrst = wr && sel && mgmt.addr == `PIMC_A_CTRL && mgmt.wdata[`PIMC_B_SWRST];
      assign ml = mode_live[g];

      always_ff @(posedge ref_clk_i or negedge rst_n_i)
        if (!rst_n_i)
          mode_pend[g] <= `PIMC_RST_MODE;
        else if (wr && sel && mgmt.addr == `PIMC_A_MODE)
          mode_pend[g] <= mgmt.wdata;

      always_ff @(posedge ref_clk_i or negedge rst_n_i)
        if (!rst_n_i)
          mode_live[g] <= `PIMC_RST_MODE;
        else if (swrst)
          mode_live[g] <= mode_pend[g];

      // Software reset bit self-clears
      always_ff @(posedge ref_clk_i or negedge rst_n_i)
        if (!rst_n_i)
          ctrl[g] <= `PIMC_RST_CTRL;
        else if (wr && sel && mgmt.addr == `PIMC_A_CTRL)
          ctrl[g] <= {1'b0, mgmt.wdata[14:0]};

      always_ff @(posedge ref_clk_i or negedge rst_n_i)
        if (!rst_n_i)
        begin
          adv[g] <= `PIMC_RST_ADV;
          mac_an[g] <= 1'b0;
        end
        else
        begin
          if (wr && sel && mgmt.addr == `PIMC_A_ADV)
            adv[g] <= mgmt.wdata;
          if (wr && sel && mgmt.addr == `PIMC_A_MACAN)
            mac_an[g] <= mgmt.wdata[`PIMC_B_MACAN];
        end

      always_comb
      begin
        if (gmode_live == `PIMC_MACMODE_QSGMII)
          mm = pimc_pkg::PIMC_MAC_QSGMII;
        else if (ml[`PIMC_B_MACPROTO])
          mm = pimc_pkg::PIMC_MAC_1000X;
        else
          mm = pimc_pkg::PIMC_MAC_SGMII;
        unique case (ml[`PIMC_B_MEDIA_HI:`PIMC_B_MEDIA_LO])
          `PIMC_MEDIA_1000X: md = pimc_pkg::PIMC_MED_1000X;
          `PIMC_MEDIA_100FX: md = pimc_pkg::PIMC_MED_100FX;
          `PIMC_MEDIA_XFER: md = pimc_pkg::PIMC_MED_XFER;
          default: md = pimc_pkg::PIMC_MED_COPPER;
        endcase
      end
      // Bit 10 doubles as sense enable; fiber and transfer codes leave it clear
      assign sense_on = ml[`PIMC_B_SENSE] && !uni;
      assign uni = ctrl[g][`PIMC_B_UNIDIR] && !ctrl[g][`PIMC_B_ANEN] && !mac_an[g]
                   && (md == pimc_pkg::PIMC_MED_1000X || md == pimc_pkg::PIMC_MED_100FX);

      // Sensed media: preference wins when both present
      always_ff @(posedge ref_clk_i or negedge rst_n_i)
        if (!rst_n_i)
          media_sel[g] <= 2'h0;
        else if (!sense_on)
          media_sel[g] <= (md == pimc_pkg::PIMC_MED_COPPER) ? `PIMC_SEL_COPPER : `PIMC_SEL_FIBER;
        else if (fib_s2[g] && (ml[`PIMC_B_PREF] || !cu_s2[g]))
          media_sel[g] <= `PIMC_SEL_FIBER;
        else if (cu_s2[g])
          media_sel[g] <= `PIMC_SEL_COPPER;

      // Transfer with QSGMII only lives on port 0
      assign port_active_o[g] = !(md == pimc_pkg::PIMC_MED_XFER && mm == pimc_pkg::PIMC_MAC_QSGMII && g != 0);
      assign ok = (md == pimc_pkg::PIMC_MED_XFER) ? det_s2[g] && sl_s2[g] : fib_s2[g];

      always_ff @(posedge ref_clk_i or negedge rst_n_i)
        if (!rst_n_i)
        begin
          mac_mode_o[g] <= 2'h0; media_mode_o[g] <= 2'h0; mac_an_run_o[g] <= 1'b0;
          fiber_an_run_o[g] <= 1'b0; speed_1000_only_o[g] <= 1'b0; tx_enable_o[g] <= 1'b0;
          link_up_o[g] <= 1'b0; diag_enable_o[g] <= 1'b0; led_link_o[g] <= 1'b0; led_fault_en_o[g] <= 1'b1;
        end
        else
        begin
          mac_mode_o[g] <= mm;
          media_mode_o[g] <= md;
          mac_an_run_o[g] <= mac_an[g];
          fiber_an_run_o[g] <= md == pimc_pkg::PIMC_MED_1000X && ctrl[g][`PIMC_B_ANEN];
          // Protocol bit still picks 1000BASE-X per port inside a quad link
          speed_1000_only_o[g] <= ml[`PIMC_B_MACPROTO] || md == pimc_pkg::PIMC_MED_1000X;
          link_up_o[g] <= port_active_o[g] && ok;
          tx_enable_o[g] <= port_active_o[g] && (ok || uni);
          diag_enable_o[g] <= md == pimc_pkg::PIMC_MED_1000X || md == pimc_pkg::PIMC_MED_100FX;
          led_link_o[g] <= port_active_o[g] && ok;
          led_fault_en_o[g] <= md != pimc_pkg::PIMC_MED_XFER;
        end
    end
  endgenerate

  // Two live QSGMII channels, two idle windows
  assign qsgmii_lanes_o = (gmode_live == `PIMC_MACMODE_QSGMII) ? 2'h2 : 2'h0;

  // ====================
  // Read path and acknowledge
  logic [15:0] rd;
  always_comb
  begin
    rd = 16'h0000;
    unique case (mgmt.addr)
      `PIMC_A_GLOBAL: rd[`PIMC_B_MACMODE_HI:`PIMC_B_MACMODE_LO] = gmode_live;
      `PIMC_A_BCAST: rd[`PIMC_B_BCAST] = bcast;
      `PIMC_A_MODE: rd = mode_live[mgmt.port];
      `PIMC_A_CTRL: rd = ctrl[mgmt.port];
      `PIMC_A_STAT:
      begin
        rd[`PIMC_B_UNIABLE] = 1'b1;
        rd[`PIMC_B_LINKOK] = link_up_o[mgmt.port];
      end
      `PIMC_A_MACAN: rd[`PIMC_B_MACAN] = mac_an[mgmt.port];
      `PIMC_A_MEDSEL: rd[`PIMC_B_SEL_HI:`PIMC_B_SEL_LO] = media_sel[mgmt.port];
      `PIMC_A_ADV: rd = adv[mgmt.port];
      default: rd = 16'h0000;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      mgmt.ack <= 1'b0;
      mgmt.rdata <= 16'h0000;
    end
    else
    begin
      mgmt.ack <= mgmt.req && !mgmt.ack;
      if (mgmt.req && !mgmt.ack)
        mgmt.rdata <= rd;
    end
endmodule : pimc_phy

// File: inc/pimc_consts.svh
// Constants for the PHY interface mode configuration block
// Operation
// - MAC mode field 01 selects QSGMII
// - Field 00, protocol bit 0: SGMII
// - Field 00, protocol bit 1: 1000BASE-X MAC
// - 1000BASE-X MAC runs 1000 Mbps only
// - Software drops 10/100 advertisement then
// - MAC autoneg per port via bit 7
// - Global field once; broadcast updates all ports
// - QSGMII ports pick 1000BASE-X or SGMII
// - QSGMII carries two data channels only
// - Media field 010 X, 011 FX, 001 transfer
// - Mode change commits on software reset
// - Bit 10 sense enable, bit 11 preference
// - Sensed media reported in bits 7:6
// - Transfer mode with QSGMII uses port 0
// - 1000BASE-X media status in registers 0-15
// - Fiber autoneg only when control bit 12
// - Generator, CRC counters, loopback on fiber
// - Signal detect needed before transfer link
// - Transfer mode LEDs except col/dup/fault
// - Control bit 5 forces unidirectional transmit
// - Status bit 7 reports unidirectional ability
// - Unidirectional needs autoneg off, sensing off
// - Mode register reads the committed mode
`ifndef PIMC_CONSTS_SVH
`define PIMC_CONSTS_SVH
// Wishbone word addresses (byte address >> 2)
`define PIMC_A_GLOBAL 4'h0
`define PIMC_A_BCAST 4'h1
`define PIMC_A_MODE 4'h2
`define PIMC_A_CTRL 4'h3
`define PIMC_A_STAT 4'h4
`define PIMC_A_MACAN 4'h5
`define PIMC_A_MEDSEL 4'h6
`define PIMC_A_ADV 4'h7
`define PIMC_A_PORT 4'h8
`define PIMC_B_MACMODE_HI 15
`define PIMC_B_MACMODE_LO 14
`define PIMC_B_MACPROTO 12
`define PIMC_B_PREF 11
`define PIMC_B_SENSE 10
`define PIMC_B_MEDIA_HI 10
`define PIMC_B_MEDIA_LO 8
`define PIMC_B_SWRST 15
`define PIMC_B_ANEN 12
`define PIMC_B_UNIDIR 5
`define PIMC_B_LINKOK 2
`define PIMC_B_UNIABLE 7
`define PIMC_B_MACAN 7
`define PIMC_B_SEL_HI 7
`define PIMC_B_SEL_LO 6
`define PIMC_B_BCAST 0
`define PIMC_B_ADV10 5
`define PIMC_B_ADV100 7
`define PIMC_MACMODE_SGMII 2'h0
`define PIMC_MACMODE_QSGMII 2'h1
`define PIMC_MEDIA_XFER 3'h1
`define PIMC_MEDIA_1000X 3'h2
`define PIMC_MEDIA_100FX 3'h3
`define PIMC_RST_MODE 16'h0000
`define PIMC_RST_CTRL 16'h1000
`define PIMC_RST_ADV 16'h01e1
`define PIMC_SEL_FIBER 2'h1
`define PIMC_SEL_COPPER 2'h2
`endif

// File: inc/pimc_pkg.sv
// Types for the PHY interface mode configuration block
package pimc_pkg;
  typedef enum logic [1:0] {PIMC_MAC_SGMII, PIMC_MAC_QSGMII, PIMC_MAC_1000X} pimc_mac_e;
  typedef enum logic [1:0] {PIMC_MED_COPPER, PIMC_MED_1000X, PIMC_MED_100FX, PIMC_MED_XFER} pimc_media_e;
endpackage : pimc_pkg

// File: inc/pimc_if.sv
// Management link between the controller and the PHY mode logic
interface pimc_if #(parameter int PORTS = 2);
  logic [3:0] addr;
  logic [0:0] port;
  logic we;
  logic req;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic ack;
  modport phy (input addr, port, we, req, wdata, output rdata, ack);
  modport ctl (output addr, port, we, req, wdata, input rdata, ack);
endinterface : pimc_if

// File: verilog/pimc_ctl.sv
// Controller end: Wishbone registers become management accesses
`include "pimc_consts.svh"
module pimc_ctl (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  pimc_if.ctl mgmt
);
  // ====================
  // Wishbone: word 0..7 map to the device registers, port in bit 5
  // software must clear 10/100 advertisement and autoneg itself
  logic busy;
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      busy <= 1'b0;
      mgmt.req <= 1'b0;
      mgmt.we <= 1'b0;
      mgmt.addr <= 4'h0;
      mgmt.port <= 1'b0;
      mgmt.wdata <= 16'h0000;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= 1'b0;
      if (!busy && !wb_ack_o && wb_cyc_i && wb_stb_i)
      begin
        if (wb_adr_i[3:0] >= `PIMC_A_PORT)
        begin
          wb_ack_o <= 1'b1; // Unmapped: reads zero, writes dropped
          wb_dat_o <= 32'h00000000;
        end
        else
        begin
          busy <= 1'b1;
          mgmt.req <= 1'b1;
          mgmt.we <= wb_we_i && wb_sel_i[0] && wb_sel_i[1];
          mgmt.addr <= wb_adr_i[3:0];
          mgmt.port <= wb_adr_i[5];
          mgmt.wdata <= wb_dat_i[15:0];
        end
      end
      else if (busy && mgmt.ack)
      begin
        busy <= 1'b0;
        mgmt.req <= 1'b0;
        wb_ack_o <= 1'b1;
        wb_dat_o <= {16'h0000, mgmt.rdata};
      end
    end
endmodule : pimc_ctl

// File: test/pimc_properties.sv
// Link-level checks between the controller and the device end
module pimc_properties (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] addr,
  input wire logic [0:0] port,
  input wire logic we,
  input wire logic req,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic ack
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // ==========================================================
  // Handshake
  sequence s_take;
    req && !ack;
  endsequence
  sequence s_done;
    ack ##1 !req;
  endsequence
  chk_link_answer: assert property (s_take |=> s_done)
    else $error("link answer missing or request not released");
  chk_ack_pulse: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  chk_ack_cause: assert property (ack |-> $past(req))
    else $error("ack without request");
  chk_req_steady: assert property (s_take |=> $stable({addr, port, we, wdata}))
    else $error("request changed before ack");
  chk_req_hold: assert property (s_take |=> req)
    else $error("request dropped early");
  // ==========================================================
  // Read data
  chk_stat_ability: assert property (ack && !we && addr == 4'h4 |-> rdata[7])
    else $error("unidirectional ability not reported");
  chk_rdata_cause: assert property ($changed(rdata) |-> ack)
    else $error("read data moved without answer");
  chk_reset_clear: assert property (ack && !we && addr == 4'h3 |-> !rdata[15])
    else $error("software reset bit reads back set");
endmodule : pimc_properties

// File: test/pimc_tb.sv
// Self-checking bench: Wishbone controller joined to the device end
module pimc_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_i = 0, rst_n_i = 0, wb_cyc = 0, wb_stb = 0, wb_we = 0;
  logic [5:0] wb_adr = '0;
  logic [31:0] wb_dat = '0, wb_dat_o;
  logic wb_ack_o;
  logic [1:0] sig_det = 0, fiber_ok = 0, copper_ok = 0, sfp_link = 0;
  logic [1:0] mac_mode_o [2], media_mode_o [2];
  logic [1:0] port_active_o, mac_an_run_o, fiber_an_run_o, spd_o, tx_enable_o, link_up_o, led_link_o, qsgmii_lanes_o;
  logic [15:0] q;
  logic [1:0] diag_o, led_fault_o;
  int num_errors = 0, total_checks = 0;
  pimc_if #(.PORTS(2)) mgmt_if ();
  pimc_ctl pimc_ctl_inst (.ref_clk_i, .rst_n_i, .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat), .wb_dat_o, .wb_ack_o, .mgmt(mgmt_if));
  pimc_phy #(.PORTS(2)) pimc_phy_inst (.ref_clk_i, .rst_n_i, .mgmt(mgmt_if), .sig_det_i(sig_det),
    .fiber_ok_i(fiber_ok), .copper_ok_i(copper_ok), .sfp_link_i(sfp_link), .mac_mode_o, .media_mode_o,
    .port_active_o, .mac_an_run_o, .fiber_an_run_o, .speed_1000_only_o(spd_o), .tx_enable_o, .link_up_o,
    .diag_enable_o(diag_o), .led_link_o, .led_fault_en_o(led_fault_o), .qsgmii_lanes_o);
  pimc_properties pimc_properties_inst (.ref_clk_i, .rst_n_i, .addr(mgmt_if.addr), .port(mgmt_if.port),
    .we(mgmt_if.we), .req(mgmt_if.req), .wdata(mgmt_if.wdata), .rdata(mgmt_if.rdata), .ack(mgmt_if.ack));
  initial
  begin
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  // ==========================================================
  // Bus and compare helpers
  task automatic wrap_up;
    if (num_errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("Error t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // Holds the cycle until ack is sampled; a lost answer ends the run
  task automatic wb(input logic w, input logic [5:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    wb_cyc <= 1;
    wb_stb <= 1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat <= {16'h0000, d};
    do
    begin
      @(posedge ref_clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o[15:0];
    wb_cyc <= 0;
    wb_stb <= 0;
    if (n >= 20)
    begin
      num_errors++;
      wrap_up();
    end
  endtask : wb
  task automatic rc(input logic [5:0] a, input logic [15:0] e);
    wb(0, a, 16'h0000);
    chk(q, e);
  endtask : rc
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    rc(6'h03, 16'h1000);
    rc(6'h07, 16'h01e1);
    rc(6'h08, 16'h0000);
    wb(0, 6'h24, 16'h0000);
    chk(q[7], 1);
    chk(led_fault_o, 2'h3);
    chk(diag_o, 2'h0);
  endtask : t_reset
  task automatic t_mac;
    wb(1, 6'h02, 16'h1000);
    wb(1, 6'h07, 16'h0001);
    rc(6'h07, 16'h0001);
    rc(6'h02, 16'h0000);
    wb(1, 6'h03, 16'h8000);
    rc(6'h02, 16'h1000);
    chk(mac_mode_o[0], 2'h2);
    chk(mac_mode_o[1], 2'h0);
    chk(spd_o[0], 1);
    wb(1, 6'h00, 16'h4000);
    wb(1, 6'h03, 16'h8000);
    rc(6'h00, 16'h4000);
    chk(mac_mode_o[1], 2'h1);
    chk(qsgmii_lanes_o, 2'h2);
    chk(spd_o, 2'h1);
    wb(1, 6'h00, 16'h0000);
    wb(1, 6'h02, 16'h0000);
    wb(1, 6'h03, 16'h8000);
    rc(6'h02, 16'h0000);
    chk(mac_mode_o[0], 2'h0);
  endtask : t_mac
  task automatic t_media;
    logic [2:0] code [3] = '{3'h1, 3'h2, 3'h3};
    logic [1:0] expm [3] = '{2'h3, 2'h1, 2'h2};
    wb(1, 6'h01, 16'h0001);
    for (int i = 0; i < 3; i++)
    begin
      wb(1, 6'h02, {5'h00, code[i], 8'h00});
      wb(1, 6'h03, 16'h8000);
      rc(6'h22, {5'h00, code[i], 8'h00});
      chk(media_mode_o[0], expm[i]);
      chk(media_mode_o[1], expm[i]);
      chk(diag_o, (i == 0) ? 2'h0 : 2'h3);
    end
    // Transfer mode behind a quad link, link held off until signal detect
    wb(1, 6'h00, 16'h4000);
    wb(1, 6'h02, 16'h0100);
    wb(1, 6'h03, 16'h8000);
    sfp_link <= 2'h3;
    rc(6'h01, 16'h0001);
    chk(port_active_o, 2'h1);
    chk(link_up_o[0], 0);
    sig_det <= 2'h3;
    rc(6'h01, 16'h0001);
    chk(link_up_o[0], 1);
    chk(led_link_o[0], 1);
    chk(led_fault_o, 2'h0);
    wb(1, 6'h01, 16'h0000);
  endtask : t_media
  task automatic t_uni;
    sfp_link <= 2'h0;
    sig_det <= 2'h0;
    wb(1, 6'h02, 16'h0200);
    wb(1, 6'h03, 16'h8020);
    rc(6'h02, 16'h0200);
    chk(tx_enable_o[0], 1);
    chk(fiber_an_run_o[0], 0);
    wb(1, 6'h05, 16'h0080);
    rc(6'h05, 16'h0080);
    chk(mac_an_run_o, 2'h1);
    chk(tx_enable_o[0], 0);
    wb(1, 6'h03, 16'h1000);
    rc(6'h03, 16'h1000);
    chk(fiber_an_run_o[0], 1);
  endtask : t_uni
  // Both media present: sensing must follow the preference bit
  task automatic t_sense;
    fiber_ok <= 2'h1;
    copper_ok <= 2'h1;
    wb(1, 6'h02, 16'h0400);
    wb(1, 6'h03, 16'h9000);
    rc(6'h06, 16'h0080);
    wb(1, 6'h02, 16'h0c00);
    wb(1, 6'h03, 16'h9000);
    rc(6'h06, 16'h0040);
  endtask : t_sense
  initial
  begin
    repeat (4) @(posedge ref_clk_i);
    rst_n_i <= 1;
    t_reset();
    t_mac();
    t_media();
    t_uni();
    t_sense();
    wrap_up();
  end
endmodule : pimc_tb
